//--- hdl/tcpa_port.sv
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tcpa_port
  import tcpa_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Comparators and straps
  input  wire tcpa_sense_t       sense,
  // Port outputs
  output tcpa_power_t            power,
  output logic                   attach_detect_n,
  output logic                   load_detect_n,
  output logic                   irq
);

  // ==========================================================================
  // State
  // ==========================================================================
  tcpa_core_t     q;           // Registered state
  tcpa_core_t     d;           // Next state
  logic [NEV-1:0] ev;          // Event pulses to interrupt logic
  logic           deb_arm;     // Sink seen on the captured line
  logic           deb_done;    // Debounce complete
  logic           en_we;       // Enable register write
  logic           clr_we;      // Clear register write
  logic [NEV-1:0] irq_status;  // Sticky events
  logic [NEV-1:0] irq_enable;  // Event enables
  logic           irq_q;       // Registered interrupt line
  logic           port_on;     // Enable pin and software enable
  logic           sink_one;    // Exactly one CC line pulled by a sink
  logic           sink_same;   // Sink still on the captured line
  logic           att;         // Next state is attached
  logic           ld;          // Next load-detect level, active high
  logic           wr_commit;   // Write completes this edge
  logic           addr_hit;    // Address is mapped
  logic [31:0]    rd_word;     // Read mux result
  logic [31:0]    stat_word;   // Status register image

  // ==========================================================================
  // Sink qualification
  // ==========================================================================
  // Both lines pulled means a debug accessory, not a sink, so it never attaches
  assign sink_one  = sense.cc1_rd ^ sense.cc2_rd;
  // Polarity picks which line must keep the pulldown
  assign sink_same = q.polarity ? (sense.cc2_rd & ~sense.cc1_rd)
                                : (sense.cc1_rd & ~sense.cc2_rd);
  assign port_on   = sense.enable & q.port_en;
  assign deb_arm   = (q.fsm == FSM_DEBOUNCE) & sink_same;

  tcpa_debounce u_debounce (
    .pclk    (pclk),
    .presetn (presetn),
    .arm     (deb_arm),
    .done    (deb_done)
  );

  // ==========================================================================
  // Register decode
  // ==========================================================================
  // Completing edge: access phase with our pready high
  assign wr_commit = psel & penable & q.rsp.pready & pwrite & ~q.rsp.pslverr;
  // Status and sticky registers ignore writes without an error
  assign en_we     = wr_commit & (paddr == OFS_IRQ_EN);
  assign clr_we    = wr_commit & (paddr == OFS_IRQ_CLR);
  assign addr_hit  = (paddr == OFS_CTRL) | (paddr == OFS_STATUS) |
                     (paddr == OFS_IRQ_STAT) | (paddr == OFS_IRQ_EN) |
                     (paddr == OFS_IRQ_CLR);

  tcpa_irq u_irq (
    .pclk    (pclk),
    .presetn (presetn),
    .ev      (ev),
    .en_we   (en_we),
    .clr_we  (clr_we),
    .wdata   (pwdata[NEV-1:0]),
    .status  (irq_status),
    .enable  (irq_enable),
    .irq     (irq_q)
  );

  // Status image of the live port
  always_comb
  begin
    stat_word                        = WORD_ZERO;
    stat_word[ST_ATTACHED]           = ~q.attach_n;
    stat_word[ST_POL]                = q.polarity;
    stat_word[ST_BUS]                = q.pwr.bus_on;
    stat_word[ST_CABLE]              = q.pwr.cable_cc1 | q.pwr.cable_cc2;
    stat_word[ST_LOAD]               = ~q.load_n;
    stat_word[ST_ADV_LO +: 2]        = q.pwr.adv_level;
    stat_word[ST_FSM_LO +: FSM_W]    = q.fsm;
  end

  // Read mux; clear register and holes read zero
  always_comb
  begin
    rd_word = WORD_ZERO;
    case (paddr)
      OFS_CTRL:     rd_word[CTRL_PORT_EN] = q.port_en;
      OFS_STATUS:   rd_word = stat_word;
      OFS_IRQ_STAT: rd_word[NEV-1:0] = irq_status;
      OFS_IRQ_EN:   rd_word[NEV-1:0] = irq_enable;
      default:      rd_word = WORD_ZERO;
    endcase
  end

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb
  begin
    d  = q;
    ev = '0;

    // Start-up and attach sequencing
    case (q.fsm)
      FSM_UVLO:
      begin
        if (sense.aux_ok)
          d.fsm = FSM_SAMPLE;
      end
      FSM_SAMPLE:
      begin
        // Enable is looked at only once the supply is good
        d.fsm = port_on ? FSM_IDLE : FSM_OFF;
      end
      FSM_OFF:
      begin
        // CC monitor off; a later enable restarts watching
        if (port_on)
          d.fsm = FSM_IDLE;
      end
      FSM_IDLE:
      begin
        if (sink_one)
        begin
          d.fsm      = FSM_DEBOUNCE;
          d.polarity = sense.cc2_rd;
        end
      end
      FSM_DEBOUNCE:
      begin
        // A bounce back to open restarts from idle
        if (!sink_same)
          d.fsm = FSM_IDLE;
        else if (deb_done)
        begin
          d.fsm          = FSM_ATTACHED;
          ev[EV_ATTACH]  = 1'b1;
        end
      end
      FSM_ATTACHED:
      begin
        if (!sink_same)
        begin
          d.fsm          = FSM_IDLE;
          ev[EV_DETACH]  = 1'b1;
        end
      end
      default:
      begin
        d.fsm = FSM_UVLO;
      end
    endcase

    // Supply loss overrides every state; disable overrides idle, debounce and attached
    if (!sense.aux_ok)
    begin
      d.fsm = FSM_UVLO;
    end
    else if (!port_on && (q.fsm == FSM_IDLE || q.fsm == FSM_DEBOUNCE ||
                          q.fsm == FSM_ATTACHED))
    begin
      d.fsm = FSM_OFF;
    end
    // Detach event also covers a forced exit from attached
    if (q.fsm == FSM_ATTACHED && d.fsm != FSM_ATTACHED)
      ev[EV_DETACH] = 1'b1;

    // Outputs follow the next state so they change with it
    att             = (d.fsm == FSM_ATTACHED);
    d.attach_n      = ~att;
    d.pwr.bus_on    = att;
    // Cable power only on the line the sink is not using
    d.pwr.cable_cc1 = att & d.polarity & sense.cc1_ra;
    d.pwr.cable_cc2 = att & ~d.polarity & sense.cc2_ra;

    // Advertisement straight from the two selects; no charging-port
    // signature detection is done here, a companion part must add it
    if (!sense.charge_level_select)
      d.pwr.adv_level = ADV_DEFAULT;
    else if (sense.high_current_select)
      d.pwr.adv_level = ADV_HIGH;
    else
      d.pwr.adv_level = ADV_MEDIUM;

    // Load detect only in high-current mode with a sink on the port
    ld       = att & sense.charge_level_select & sense.high_current_select &
               sense.over_load;
    d.load_n = ~ld;
    // Events on each change of the load output, for software
    if (ld && q.load_n)
      ev[EV_LOAD_ON] = 1'b1;
    if (!ld && !q.load_n)
      ev[EV_LOAD_OFF] = 1'b1;

    // APB: answer one cycle after setup, zero wait states after that
    d.rsp.pready  = 1'b0;
    d.rsp.pslverr = 1'b0;
    d.rsp.prdata  = WORD_ZERO;
    if (psel && !penable)
    begin
      d.rsp.pready  = 1'b1;
      d.rsp.pslverr = ~addr_hit;
      if (!pwrite && addr_hit)
        d.rsp.prdata = rd_word;
    end
    if (wr_commit && paddr == OFS_CTRL)
      d.port_en = pwdata[CTRL_PORT_EN];
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q          <= '0;
      // Fields that idle high are set apart from the zero fill
      q.fsm      <= FSM_UVLO;
      q.attach_n <= 1'b1;
      q.load_n   <= 1'b1;
      q.port_en  <= PORT_EN_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from flip-flops
  assign prdata          = q.rsp.prdata;
  assign pready          = q.rsp.pready;
  assign pslverr         = q.rsp.pslverr;
  assign power           = q.pwr;
  assign attach_detect_n = q.attach_n;
  assign load_detect_n   = q.load_n;
  assign irq             = irq_q;

  // ==========================================================================
  // Checks
  // ==========================================================================
  // Outputs are registered, so most checks look one edge ahead
  attach_power_a: assert property (@(posedge pclk) disable iff (!presetn)
    (q.fsm == FSM_ATTACHED) == (!attach_detect_n && power.bus_on))
    else $error("attach output and bus power disagree with state");

  detach_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (q.fsm == FSM_ATTACHED && !sense.cc1_rd && !sense.cc2_rd)
      |=> !power.bus_on && attach_detect_n)
    else $error("bus power kept after detach");

  load_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    attach_detect_n |-> load_detect_n)
    else $error("load output low without a sink");

  load_assert_a: assert property (@(posedge pclk) disable iff (!presetn)
    (q.fsm == FSM_ATTACHED && sink_same && port_on && sense.aux_ok &&
     sense.charge_level_select && sense.high_current_select && sense.over_load)
      |=> !load_detect_n)
    else $error("heavy load not flagged");

  load_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!load_detect_n && !sense.over_load) |=> load_detect_n)
    else $error("load output held after load dropped");

  medium_adv_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sense.charge_level_select && !sense.high_current_select)
      |=> power.adv_level == ADV_MEDIUM)
    else $error("medium level not advertised");

  adv_default_a: assert property (@(posedge pclk) disable iff (!presetn)
    !sense.charge_level_select |=> power.adv_level == ADV_DEFAULT)
    else $error("default level not advertised");

  start_seq_a: assert property (@(posedge pclk) disable iff (!presetn)
    (q.fsm == FSM_SAMPLE && !port_on && sense.aux_ok) |=> q.fsm == FSM_OFF)
    else $error("start-up ignored a low enable");

  cc_watch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (q.fsm == FSM_IDLE && sink_one && port_on && sense.aux_ok)
      |=> q.fsm == FSM_DEBOUNCE)
    else $error("sink on CC not picked up");

  attach_deb_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(power.bus_on) |-> $past(q.fsm == FSM_DEBOUNCE) && $past(deb_done))
    else $error("bus power before debounce");

  cable_side_a: assert property (@(posedge pclk) disable iff (!presetn)
    power.cable_cc1 |-> q.polarity && power.bus_on && !power.cable_cc2)
    else $error("cable power on the sink line");

  load_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(sense.charge_level_select && sense.high_current_select) |=> load_detect_n)
    else $error("load detect outside high-current mode");

  cable_other_a: assert property (@(posedge pclk) disable iff (!presetn)
    power.cable_cc2 |-> !q.polarity && power.bus_on && !power.cable_cc1)
    else $error("cable power on the wrong line");

  high_adv_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sense.charge_level_select && sense.high_current_select)
      |=> power.adv_level == ADV_HIGH)
    else $error("high level not advertised");

  supply_loss_a: assert property (@(posedge pclk) disable iff (!presetn)
    !sense.aux_ok |=> q.fsm == FSM_UVLO && attach_detect_n && !power.bus_on)
    else $error("port running without standby supply");

  port_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sense.aux_ok && !port_on && q.fsm != FSM_UVLO && q.fsm != FSM_SAMPLE)
      |=> q.fsm == FSM_OFF && !power.bus_on)
    else $error("disabled port still active");

  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready && pslverr == !$past(addr_hit))
    else $error("register access not answered");

endmodule : tcpa_port
`default_nettype wire

//--- hdl/tcpa_pkg.sv
package tcpa_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS = 25;   // 40 MHz pclk
  localparam int unsigned DEBOUNCE_US   = 100;  // Attach debounce, plain default
  // Least time: round up to whole cycles
  localparam int unsigned DEBOUNCE_CYC  =
    (DEBOUNCE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEB_W         = 12;
  localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEBOUNCE_CYC - 1);
  localparam logic [DEB_W-1:0] DEB_ONE  = 12'h001;
  localparam logic [DEB_W-1:0] DEB_ZERO = 12'h000;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam int unsigned ADDR_W       = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;  // Port control, rw
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h04;  // Live port state, ro
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;  // Sticky events, ro
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 8'h0c;  // Event enables, rw
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 8'h10;  // Write one to clear, wo

  // Control fields
  localparam int unsigned CTRL_PORT_EN = 0;
  localparam logic        PORT_EN_RST  = 1'b1;

  // Status fields
  localparam int unsigned ST_ATTACHED = 0;
  localparam int unsigned ST_POL      = 1;
  localparam int unsigned ST_BUS      = 2;
  localparam int unsigned ST_CABLE    = 3;
  localparam int unsigned ST_LOAD     = 4;
  localparam int unsigned ST_ADV_LO   = 5;
  localparam int unsigned ST_FSM_LO   = 8;
  localparam int unsigned FSM_W       = 3;

  // Events, one bit each in the interrupt registers
  localparam int unsigned NEV         = 4;
  localparam int unsigned EV_ATTACH   = 0;
  localparam int unsigned EV_DETACH   = 1;
  localparam int unsigned EV_LOAD_ON  = 2;
  localparam int unsigned EV_LOAD_OFF = 3;

  // Advertised current level on the CC line
  localparam logic [1:0] ADV_DEFAULT = 2'h0;
  localparam logic [1:0] ADV_MEDIUM  = 2'h1;
  localparam logic [1:0] ADV_HIGH    = 2'h2;

  localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [FSM_W-1:0] {
    FSM_UVLO, FSM_SAMPLE, FSM_OFF, FSM_IDLE, FSM_DEBOUNCE, FSM_ATTACHED
  } tcpa_fsm_t;

  // Comparator and strap inputs, already synchronous
  typedef struct packed {
    logic aux_ok;               // Standby supply above lockout
    logic enable;               // Device enable input
    logic cc1_rd;               // Sink pulldown seen on CC1
    logic cc2_rd;               // Sink pulldown seen on CC2
    logic cc1_ra;               // Cable marker seen on CC1
    logic cc2_ra;               // Cable marker seen on CC2
    logic over_load;            // Output current above load threshold
    logic charge_level_select;  // Non-default advertisement
    logic high_current_select;  // High rather than medium
  } tcpa_sense_t;

  // Power switch and advertisement drive
  typedef struct packed {
    logic       bus_on;     // Bus power switch closed
    logic       cable_cc1;  // Cable power onto CC1
    logic       cable_cc2;  // Cable power onto CC2
    logic [1:0] adv_level;  // Advertised current level
  } tcpa_power_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tcpa_apb_rsp_t;

  typedef struct packed {
    tcpa_fsm_t     fsm;
    logic          polarity;  // 0: sink on CC1, 1: sink on CC2
    logic          attach_n;
    logic          load_n;
    tcpa_power_t   pwr;
    logic          port_en;
    tcpa_apb_rsp_t rsp;
  } tcpa_core_t;

  typedef struct packed {
    logic [DEB_W-1:0] cnt;
    logic             done;
  } tcpa_deb_t;

  typedef struct packed {
    logic [NEV-1:0] status;
    logic [NEV-1:0] enable;
    logic           irq;
  } tcpa_irq_t;

endpackage : tcpa_pkg

//--- hdl/tcpa_debounce.sv
`timescale 1ns/1ps
`default_nettype none
module tcpa_debounce
  import tcpa_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Condition to qualify
  input  wire logic arm,
  output logic      done
);

  tcpa_deb_t q;  // Registered state
  tcpa_deb_t d;  // Next state

  // ==========================================================================
  // Count while armed; any drop restarts the wait
  // ==========================================================================
  always_comb
  begin
    d = q;
    if (!arm)
    begin
      d.cnt  = DEB_ZERO;
      d.done = 1'b0;
    end
    else if (q.cnt != DEB_LAST)
    begin
      d.cnt  = q.cnt + DEB_ONE;
      d.done = 1'b0;
    end
    else
    begin
      d.done = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end

  assign done = q.done;

  // Done only after the full count of armed cycles
  debounce_full_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(q.done) |-> q.cnt == DEB_LAST && $past(arm))
    else $error("debounce finished early");

endmodule : tcpa_debounce
`default_nettype wire

//--- hdl/tcpa_irq.sv
`timescale 1ns/1ps
`default_nettype none
module tcpa_irq
  import tcpa_pkg::*;
(
  // Clock and reset
  input  wire logic           pclk,
  input  wire logic           presetn,
  // Event pulses
  input  wire logic [NEV-1:0] ev,
  // Software writes
  input  wire logic           en_we,
  input  wire logic           clr_we,
  input  wire logic [NEV-1:0] wdata,
  // State to software and system
  output logic      [NEV-1:0] status,
  output logic      [NEV-1:0] enable,
  output logic                irq
);

  tcpa_irq_t q;  // Registered state
  tcpa_irq_t d;  // Next state

  // ==========================================================================
  // Sticky status: a new event beats a clear in the same cycle
  // ==========================================================================
  always_comb
  begin
    d = q;
    if (en_we)
      d.enable = wdata;
    for (int i = 0; i < NEV; i++)
    begin
      if (ev[i])
        d.status[i] = 1'b1;
      else if (clr_we && wdata[i])
        d.status[i] = 1'b0;
    end
    // Registered so the pin never glitches
    d.irq = |(d.status & d.enable);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end

  assign status = q.status;
  assign enable = q.enable;
  assign irq    = q.irq;

  // An event is never lost to a clear
  set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    |ev |=> |(status & $past(ev)))
    else $error("event lost in status register");

endmodule : tcpa_irq
`default_nettype wire

//--- tb/tcpa_sink_model.sv
`timescale 1ns/1ps
`default_nettype none
// =========
// Sink across the CC link
// =========
module tcpa_sink_model
  import tcpa_pkg::*;
(
  // Scenario controls
  input  wire logic       present,
  input  wire logic       flip,
  input  wire logic       marker,
  input  wire logic       heavy,
  // Advertisement seen on CC
  input  wire logic [1:0] adv_level,
  // Terminations and draw
  output logic            cc1_rd,
  output logic            cc2_rd,
  output logic            cc1_ra,
  output logic            cc2_ra,
  output logic            over_load
);
  // Pulldown on one line only, by plug orientation
  assign cc1_rd = present & ~flip;
  assign cc2_rd = present & flip;
  // Marker sits on the line the sink leaves free
  assign cc1_ra = present & marker & flip;
  assign cc2_ra = present & marker & ~flip;
  // Draws heavily only while high current is offered; backs off at once
  assign over_load = present & heavy & (adv_level == ADV_HIGH);
endmodule : tcpa_sink_model
`default_nettype wire

//--- tb/tcpa_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tcpa_port_tb
  import tcpa_pkg::*;
;
  // =========
  // Signals
  // =========
  logic        pclk      = 1'h0;
  logic        presetn   = 1'h0;  // Reset held from time zero
  logic        psel      = 1'h0;
  logic        penable   = 1'h0;
  logic        pwrite    = 1'h0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0;
  logic        aux_ok    = 1'h0;
  logic        enable_in = 1'h0;
  logic        chg_sel   = 1'h1;  // Strapped for high current
  logic        hi_sel    = 1'h1;  // Peer load output, idle high
  logic        present   = 1'h0;
  logic        flip      = 1'h0;
  logic        marker    = 1'h1;
  logic        heavy     = 1'h0;
  logic        cc1_rd, cc2_rd, cc1_ra, cc2_ra, over_load;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  tcpa_sense_t sense;
  tcpa_power_t power;
  logic        attach_detect_n;
  logic        load_detect_n;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          errors      = 0;
  int          check_count = 0;

  // Clock, 25 ns period
  always #12.5 pclk = ~pclk;
  assign sense = {aux_ok, enable_in, cc1_rd, cc2_rd, cc1_ra, cc2_ra, over_load, chg_sel, hi_sel};

  tcpa_port tcpa_port_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sense(sense), .power(power), .attach_detect_n(attach_detect_n),
    .load_detect_n(load_detect_n), .irq(irq));
  tcpa_sink_model tcpa_sink_model_i (.present(present), .flip(flip), .marker(marker),
    .heavy(heavy), .adv_level(power.adv_level), .cc1_rd(cc1_rd), .cc2_rd(cc2_rd),
    .cc1_ra(cc1_ra), .cc2_ra(cc2_ra), .over_load(over_load));

  // =========
  // Helpers; all called just after a rising edge
  // =========
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // One APB transfer; request held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel   <= 1'h1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    check(32'(n), 32'h1, "apb wait");
    // Idle edge, so a following setup never overwrites this release
    @(posedge pclk);
  endtask : apb

  // Bounded wait, debounce plus margin
  task automatic wait_attach(input logic exp_n);
    int n;
    n = 0;
    while (attach_detect_n !== exp_n && n < 4100)
    begin
      @(posedge pclk);
      n++;
    end
    check(32'(attach_detect_n), 32'(exp_n), "attach");
  endtask : wait_attach

  // =========
  // Scenarios
  // =========
  task automatic t_reset();
    check(32'(attach_detect_n), 32'h1, "attach rst");
    check(32'(load_detect_n), 32'h1, "load rst");
    check(32'(power.bus_on), 32'h0, "bus rst");
  endtask : t_reset

  // Disabled device must ignore a waiting sink
  task automatic t_start();
    aux_ok  <= 1'h1;
    present <= 1'h1;
    repeat (4) @(posedge pclk);
    apb(1'h0, OFS_STATUS, WORD_ZERO);
    check(32'(rd[10:8]), 32'h2, "off state");
    check(32'(attach_detect_n), 32'h1, "off attach");
    enable_in <= 1'h1;
    present   <= 1'h0;
    repeat (4) @(posedge pclk);
    apb(1'h0, OFS_STATUS, WORD_ZERO);
    check(32'(rd[10:8]), 32'h3, "idle state");
  endtask : t_start

  task automatic t_attach(input logic side);
    flip    <= side;
    present <= 1'h1;
    @(posedge pclk);
    wait_attach(1'h0);
    check(32'(power.bus_on), 32'h1, "bus on");
    check(32'({power.cable_cc1, power.cable_cc2}), side ? 32'h2 : 32'h1, "cable");
    check(32'(load_detect_n), 32'h1, "light load");
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h1, "irq attach");
    apb(1'h0, OFS_STATUS, WORD_ZERO);
    check(32'(rd[1]), 32'(side), "polarity");
    apb(1'h0, OFS_IRQ_STAT, WORD_ZERO);
    check(rd, 32'h1, "irq stat");
    apb(1'h1, OFS_IRQ_CLR, 32'h1);
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h0, "irq clear");
  endtask : t_attach

  // Peer load pulls our select low and back
  task automatic t_load();
    heavy <= 1'h1;
    repeat (3) @(posedge pclk);
    check(32'(load_detect_n), 32'h0, "load on");
    check(32'(irq), 32'h0, "masked event");
    hi_sel <= 1'h0;
    repeat (3) @(posedge pclk);
    check(32'(power.adv_level), 32'(ADV_MEDIUM), "medium");
    check(32'(load_detect_n), 32'h1, "load off lo sel");
    hi_sel <= 1'h1;
    repeat (3) @(posedge pclk);
    check(32'(load_detect_n), 32'h0, "load again");
    heavy <= 1'h0;
    repeat (3) @(posedge pclk);
    check(32'(load_detect_n), 32'h1, "load released");
  endtask : t_load

  task automatic t_detach(input logic [3:0] stat);
    present <= 1'h0;
    repeat (3) @(posedge pclk);
    check(32'(attach_detect_n), 32'h1, "detach");
    check(32'({power.bus_on, power.cable_cc1, power.cable_cc2}), 32'h0, "power off");
    check(32'(irq), 32'h1, "irq detach");
    apb(1'h0, OFS_IRQ_STAT, WORD_ZERO);
    check(rd, 32'(stat), "stat detach");
    apb(1'h1, OFS_IRQ_CLR, 32'hf);
  endtask : t_detach

  // Every select combination, ends strapped high
  task automatic t_adv();
    logic [1:0] exp [4];
    exp = '{ADV_DEFAULT, ADV_DEFAULT, ADV_MEDIUM, ADV_HIGH};
    for (int i = 0; i < 4; i++)
    begin
      chg_sel <= i[1];
      hi_sel  <= i[0];
      repeat (3) @(posedge pclk);
      check(32'(power.adv_level), 32'(exp[i]), "adv level");
    end
  endtask : t_adv

  task automatic t_err();
    apb(1'h0, 8'h14, WORD_ZERO);
    check({rd[30:0], err}, 32'h1, "unmapped");
    apb(1'h0, OFS_CTRL, WORD_ZERO);
    check(rd, 32'h1, "ctrl reset");
    apb(1'h1, OFS_CTRL, WORD_ZERO);
    apb(1'h0, OFS_STATUS, WORD_ZERO);
    check(32'(rd[10:8]), 32'h2, "sw disable");
    apb(1'h1, OFS_CTRL, 32'h1);
    apb(1'h0, OFS_STATUS, WORD_ZERO);
    check(32'(rd[10:8]), 32'h3, "sw enable");
  endtask : t_err

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  // =========
  // Main sequence and watchdog
  // =========
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset();
    apb(1'h1, OFS_IRQ_EN, 32'h3);
    t_start();
    t_attach(1'h0);
    t_load();
    t_detach(4'he);
    t_adv();
    t_attach(1'h1);
    t_detach(4'h2);
    t_err();
    test_done();
  end

  // Whole run needs under 12000 cycles
  initial
  begin
    #500_000;
    errors++;
    test_done();
  end
endmodule : tcpa_port_tb
`default_nettype wire
